// file: rtl/led_matrix_serial_loader.sv
// Serial loader, pixel latches and control words of the LED driver.
`timescale 1ns/10ps
module led_matrix_serial_loader
   import led_loader_pkg::*;
#(
   parameter int FIFO_DEPTH_P = led_loader_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic chip_enable_n,
   input wire logic register_target_select,
   input wire logic display_blank,
   input wire logic osc_select,
   input wire logic osc_in,
   output logic serial_data_out,
   output logic osc_out,
   output logic osc_oe,
   output logic load_ready,
   output logic [led_loader_pkg::COLUMNS-1:0] column_drive,
   output logic [led_loader_pkg::ROWS-2:0] row_drive,
   output logic [1:0] peak_current
);
   import led_loader_pkg::*;

   // ==========================================================
   // State
   localparam logic [8:0] INT_DIV_LAST = 9'(INT_OSC_DIV - 1);
   localparam logic [2:0] PRE_LAST = 3'(PRESCALE_DIV - 1);

   typedef struct packed {
      logic [1:0] sclk_sync;
      logic [1:0] ce_sync;
      logic [1:0] rs_sync;
      logic [1:0] din_sync;
      logic [1:0] blank_sync;
      logic [1:0] sel_sync;
      logic [1:0] osc_sync;
      logic sclk_prev;
      logic ce_prev;
      logic osc_prev;
      load_phase_e phase;
      logic rs_cap;
      logic [CTRL_BITS-1:0] ctrl_shift;
      logic [WORD_BITS-1:0] brightness_sleep_word;
      logic [WORD_BITS-1:0] output_mode_word;
      logic copy_busy;
      logic copy_target;
      logic [8:0] int_div;
      logic int_osc;
      logic [2:0] pre_count;
      logic disp_tick;
      logic serial_out;
      logic osc_out;
      logic osc_oe;
      logic load_ready;
   } state_s;

   state_s cur;
   state_s next_cur;

   // Pixel storage has no reset: its contents survive reset and sleep.
   logic [DOT_BITS-1:0] pixel_shift_register;
   logic [DOT_BITS-1:0] pixel_latch;

   // Synchronised pin levels, edges and FIFO handshake.
   logic sclk_s;
   logic ce_s;
   logic rs_s;
   logic din_s;
   logic osc_s;
   logic sclk_rise;
   logic ce_fall;
   logic osc_rise;
   logic running;
   logic push_valid;
   logic push_ready;
   logic [FIFO_WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic pop_fire;
   logic [FIFO_WIDTH-1:0] pop_data;
   logic pixel_shift_en;
   logic pixel_copy_en;

   // ==========================================================
   // Pin sampling
   // Only the second stage of each synchroniser is read by logic.
   assign sclk_s = cur.sclk_sync[1];
   assign ce_s = cur.ce_sync[1];
   assign rs_s = cur.rs_sync[1];
   assign din_s = cur.din_sync[1];
   assign osc_s = cur.osc_sync[1];
   assign sclk_rise = sclk_s & ~cur.sclk_prev;
   assign ce_fall = ~ce_s & cur.ce_prev;
   assign osc_rise = osc_s & ~cur.osc_prev;
   assign running = cur.brightness_sleep_word[SLEEP_POS];

   // ==========================================================
   // Event FIFO between the pin sampler and the shift registers
   // The drain stalls during a latch copy so the copy sees a stable
   // shift register; the marker waits on full, but a data bit pushed while full is dropped.
   assign pop_ready = ~cur.copy_busy;
   assign pop_fire = pop_valid & pop_ready;

   event_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH_P)
   ) u_event_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(push_data),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .out_data(pop_data),
      .out_valid(pop_valid),
      .out_ready(pop_ready)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      next_cur = cur;
      push_valid = 1'b0;
      push_data = '0;

      // Two-flop synchronisers and previous-level copies for edges.
      next_cur.sclk_sync = {cur.sclk_sync[0], serial_clk};
      next_cur.ce_sync = {cur.ce_sync[0], chip_enable_n};
      next_cur.rs_sync = {cur.rs_sync[0], register_target_select};
      next_cur.din_sync = {cur.din_sync[0], serial_data};
      next_cur.blank_sync = {cur.blank_sync[0], display_blank};
      next_cur.sel_sync = {cur.sel_sync[0], osc_select};
      next_cur.osc_sync = {cur.osc_sync[0], osc_in};
      next_cur.sclk_prev = sclk_s;
      next_cur.ce_prev = ce_s;
      next_cur.osc_prev = osc_s;

      // Write frame sequencing: capture target, shift, then latch.
      case (cur.phase)
         PH_IDLE: begin
            if (ce_fall) begin
               next_cur.rs_cap = rs_s;
               next_cur.phase = PH_WRITE;
            end
         end
         PH_WRITE: begin
            if (ce_s) begin
               next_cur.phase = PH_END;
            end else if (sclk_rise) begin
               push_valid = 1'b1;
               push_data = {1'b0, cur.rs_cap, din_s};
            end
         end
         PH_END: begin
            if (ce_fall) begin
               next_cur.rs_cap = rs_s;
               next_cur.phase = PH_WRITE;
            end else if (~sclk_s) begin
               push_valid = 1'b1;
               push_data = {1'b1, cur.rs_cap, 1'b0};
               if (push_ready) begin
                  next_cur.phase = PH_IDLE;
               end
            end
         end
         default: begin
            next_cur.phase = PH_IDLE;
         end
      endcase

      // Drain: shift a control bit, or start a latch copy on a marker.
      if (pop_fire) begin
         if (pop_data[ENTRY_MARK]) begin
            next_cur.copy_busy = 1'b1;
            next_cur.copy_target = pop_data[ENTRY_TARGET];
         end else if (pop_data[ENTRY_TARGET]) begin
            next_cur.ctrl_shift = {cur.ctrl_shift[CTRL_BITS-2:0],
               pop_data[ENTRY_BIT]};
         end
      end

      // Control latch: selector bit picks one word, the other stays.
      if (cur.copy_busy) begin
         next_cur.copy_busy = 1'b0;
         if (cur.copy_target) begin
            if (cur.ctrl_shift[SELECT_POS]) begin
               next_cur.output_mode_word =
                  cur.ctrl_shift[WORD_BITS-1:0];
            end else begin
               next_cur.brightness_sleep_word =
                  cur.ctrl_shift[WORD_BITS-1:0];
            end
         end
      end

      // Internal oscillator runs only while awake.
      next_cur.disp_tick = 1'b0;
      if (~running) begin
         next_cur.int_div = '0;
         next_cur.int_osc = 1'b0;
      end else if (cur.int_div == INT_DIV_LAST) begin
         next_cur.int_div = '0;
         next_cur.int_osc = ~cur.int_osc;
         if (cur.sel_sync[1] & ~cur.int_osc) begin
            next_cur.disp_tick = 1'b1;
         end
      end else begin
         next_cur.int_div = cur.int_div + 1'b1;
      end

      // External oscillator, optionally prescaled by eight.
      if (~cur.sel_sync[1] & running & osc_rise) begin
         if (cur.output_mode_word[PRESCALE_POS]) begin
            next_cur.pre_count = cur.pre_count + 1'b1;
            if (cur.pre_count == PRE_LAST) begin
               next_cur.disp_tick = 1'b1;
            end
         end else begin
            next_cur.disp_tick = 1'b1;
         end
      end

      // Serial output: pass-through only in a simultaneous control write.
      if (cur.output_mode_word[DOUT_MODE_POS] & cur.rs_cap
         & (cur.phase == PH_WRITE)) begin
         next_cur.serial_out = din_s;
      end else if (cur.rs_cap) begin
         next_cur.serial_out = cur.ctrl_shift[CTRL_BITS-1];
      end else begin
         next_cur.serial_out = pixel_shift_register[0];
      end

      next_cur.osc_out = cur.int_osc;
      next_cur.osc_oe = cur.sel_sync[1];
      next_cur.load_ready = push_ready;
   end

   // ==========================================================
   // State register
   // Reset clears both control words, which leaves the part asleep.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
         cur.phase <= PH_IDLE;
         cur.ce_sync <= 2'h3;
         cur.ce_prev <= 1'b1;
         cur.brightness_sleep_word <= WORD_RESET;
         cur.output_mode_word <= WORD_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // Pixel shift register and latches
   // Bits enter at the top and move toward latch 0, so the first
   // character sent ends up leftmost once a full frame is in.
   assign pixel_shift_en = pop_fire & ~pop_data[ENTRY_MARK]
      & ~pop_data[ENTRY_TARGET];
   assign pixel_copy_en = cur.copy_busy & ~cur.copy_target;

   // The latches change only on a copy, never while shifting.
   always_ff @(posedge clk) begin
      if (pixel_shift_en) begin
         pixel_shift_register <= {pop_data[ENTRY_BIT],
            pixel_shift_register[DOT_BITS-1:1]};
      end
      if (pixel_copy_en) begin
         pixel_latch <= pixel_shift_register;
      end
   end

   // ==========================================================
   // Display scan driven from the latches and the stored word 0
   // Word 0 drives the scan directly, so new control bits being shifted
   // have no effect until they are latched.
   display_scan #(
      .COLUMNS_P(COLUMNS),
      .ROWS_P(ROWS)
   ) u_display_scan (
      .clk(clk),
      .reset_n(reset_n),
      .pixels(pixel_latch),
      .tick(cur.disp_tick),
      .ontime_code(cur.brightness_sleep_word[ONTIME_LSB +: 4]),
      .current_code(cur.brightness_sleep_word[CURRENT_LSB +: 2]),
      .run(running),
      .blank(cur.blank_sync[1]),
      .column_drive(column_drive),
      .row_drive(row_drive),
      .peak_current(peak_current)
   );

   // Outputs straight from state flip-flops.
   assign serial_data_out = cur.serial_out;
   assign osc_out = cur.osc_out;
   assign osc_oe = cur.osc_oe;
   assign load_ready = cur.load_ready;
endmodule

// file: rtl/led_loader_pkg.sv
// Shared constants and types for the serial LED matrix loader.
package led_loader_pkg;
   // ==========================================================
   // Storage geometry
   localparam int DOT_BITS = 160;
   localparam int COLUMNS = 20;
   localparam int ROWS = 8;
   localparam int CTRL_BITS = 8;
   localparam int WORD_BITS = 7;
   // ==========================================================
   // Control shift register and control word fields
   localparam int SELECT_POS = 7;
   localparam int SLEEP_POS = 6;
   localparam int CURRENT_LSB = 4;
   localparam int ONTIME_LSB = 0;
   localparam int DOUT_MODE_POS = 0;
   localparam int PRESCALE_POS = 1;
   localparam logic [6:0] WORD_RESET = 7'h00;
   // ==========================================================
   // Display timing
   localparam int PRESCALE_DIV = 8;
   localparam int REFRESH_CYCLES = 512;
   localparam int COLUMN_SLOT = REFRESH_CYCLES / COLUMNS;
   localparam int CLK_PERIOD_NS = 20;
   localparam int INT_OSC_HALF_NS = 3125;
   localparam int INT_OSC_DIV = INT_OSC_HALF_NS / CLK_PERIOD_NS;
   // ==========================================================
   // Event FIFO entries: {latch marker, target, data bit}
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 3;
   localparam int ENTRY_BIT = 0;
   localparam int ENTRY_TARGET = 1;
   localparam int ENTRY_MARK = 2;
   // Phase of one host write frame.
   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_END} load_phase_e;
   // LED on-time in display clock cycles for each brightness code.
   localparam logic [5:0] ONTIME_CYCLES [16] = '{
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09,
      6'h0b, 6'h0e, 6'h12, 6'h16, 6'h1c, 6'h24, 6'h30, 6'h3c};
endpackage

// file: rtl/event_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module event_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } fifo_s;
   fifo_s cur;
   fifo_s next_cur;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = cur.count != (AW+1)'(DEPTH);
   assign out_valid = cur.count != '0;
   assign out_data = mem[cur.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update.
   always_comb begin
      next_cur = cur;
      if (push) begin
         next_cur.wr = (cur.wr == AW'(DEPTH-1)) ? '0 : cur.wr + 1'b1;
      end
      if (pop) begin
         next_cur.rd = (cur.rd == AW'(DEPTH-1)) ? '0 : cur.rd + 1'b1;
      end
      if (push & ~pop) begin
         next_cur.count = cur.count + 1'b1;
      end else if (pop & ~push) begin
         next_cur.count = cur.count - 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // Storage array, written only on an accepted push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[cur.wr] <= in_data;
      end
   end
endmodule

// file: rtl/display_scan.sv
// Column scan and on-time modulation for the LED matrix.
`timescale 1ns/10ps
module display_scan
   import led_loader_pkg::*;
#(
   parameter int COLUMNS_P = 20,
   parameter int ROWS_P = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [COLUMNS_P*ROWS_P-1:0] pixels,
   input wire logic tick,
   input wire logic [3:0] ontime_code,
   input wire logic [1:0] current_code,
   input wire logic run,
   input wire logic blank,
   output logic [COLUMNS_P-1:0] column_drive,
   output logic [ROWS_P-2:0] row_drive,
   output logic [1:0] peak_current
);
   typedef struct packed {
      logic [8:0] refresh;
      logic [4:0] slot;
      logic [4:0] col;
      logic [COLUMNS_P-1:0] column_drive;
      logic [ROWS_P-2:0] row_drive;
      logic [1:0] peak_current;
   } scan_s;
   scan_s cur;
   scan_s next_cur;
   logic lit;
   logic [4:0] col_idx;
   logic [ROWS_P-1:0] column_bits;

   // Eight consecutive latches form one column; row 0 has no LED.
   assign col_idx = (cur.col < 5'(COLUMNS_P)) ? cur.col : 5'h00;
   assign column_bits = pixels[col_idx*ROWS_P +: ROWS_P];

   // Refresh counters advance on display ticks; drivers off in sleep.
   always_comb begin
      next_cur = cur;
      if (tick) begin
         if (cur.refresh == 9'(REFRESH_CYCLES-1)) begin
            next_cur.refresh = '0;
            next_cur.slot = '0;
            next_cur.col = '0;
         end else begin
            next_cur.refresh = cur.refresh + 1'b1;
            if (cur.slot == 5'(COLUMN_SLOT-1)) begin
               next_cur.slot = '0;
               if (cur.col != 5'(COLUMNS_P)) begin
                  next_cur.col = cur.col + 1'b1;
               end
            end else begin
               next_cur.slot = cur.slot + 1'b1;
            end
         end
      end
      lit = run & ~blank & (cur.col < 5'(COLUMNS_P))
         & ({1'b0, cur.slot} < ONTIME_CYCLES[ontime_code]);
      next_cur.column_drive = lit
         ? ({{(COLUMNS_P-1){1'b0}}, 1'b1} << cur.col) : '0;
      next_cur.row_drive = lit ? column_bits[ROWS_P-1:1] : '0;
      next_cur.peak_current = run ? current_code : 2'h0;
   end

   // State register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign column_drive = cur.column_drive;
   assign row_drive = cur.row_drive;
   assign peak_current = cur.peak_current;
endmodule

// file: sim/led_loader_monitor.sv
// Port assertions for the serial LED matrix loader.
`timescale 1ns/10ps
module led_loader_monitor #(
   parameter int FIFO_DEPTH_P = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic chip_enable_n,
   input wire logic register_target_select,
   input wire logic display_blank,
   input wire logic osc_select,
   input wire logic osc_in,
   input wire logic serial_data_out,
   input wire logic osc_out,
   input wire logic osc_oe,
   input wire logic load_ready,
   input wire logic [19:0] column_drive,
   input wire logic [6:0] row_drive,
   input wire logic [1:0] peak_current
);
   // ==========================================================
   // Checks
   // All checks run on the system clock and pause during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   rst_clear_a: assert property ($rose(reset_n) |->
      peak_current == 2'h0 && row_drive == 7'h00)
      else $error("outputs not cleared after reset");
   blank_dark_a: assert property (display_blank [*4] |-> row_drive == 7'h00)
      else $error("rows driven while blanked");
   col_onehot_a: assert property ($onehot0(column_drive))
      else $error("more than one column driven");
   row_col_a: assert property (row_drive != 7'h00 |->
      column_drive != 20'h00000)
      else $error("rows driven with no column");
   ctrl_hold_a: assert property (!chip_enable_n |->
      $stable(peak_current))
      else $error("current code changed during a write");
   col_order_a: assert property ((column_drive != 20'h00000 &&
      $past(column_drive) != 20'h00000 &&
      column_drive != $past(column_drive)) |->
      column_drive == ($past(column_drive) << 1))
      else $error("column scan out of order");
   osc_drive_a: assert property ($stable(osc_select) [*4] |->
      osc_oe == osc_select)
      else $error("oscillator pin enable wrong");
   no_drop_a: assert property ($past(reset_n, 4) |-> load_ready)
      else $error("bit buffer refused a bit");
endmodule
bind led_matrix_serial_loader led_loader_monitor #(
   .FIFO_DEPTH_P(FIFO_DEPTH_P)) mon (.clk(clk), .reset_n(reset_n),
   .serial_clk(serial_clk), .serial_data(serial_data),
   .chip_enable_n(chip_enable_n),
   .register_target_select(register_target_select),
   .display_blank(display_blank), .osc_select(osc_select),
   .osc_in(osc_in), .serial_data_out(serial_data_out),
   .osc_out(osc_out), .osc_oe(osc_oe), .load_ready(load_ready),
   .column_drive(column_drive), .row_drive(row_drive),
   .peak_current(peak_current));

// file: sim/serial_host.sv
// Behavioural host that writes frames over the serial pins.
`timescale 1ns/10ps
module serial_host (
   input wire logic clk,
   output logic serial_clk,
   output logic serial_data,
   output logic chip_enable_n,
   output logic register_target_select
);
   // ==========================================================
   // Pin driving
   // Pins start idle with the frame closed.
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      chip_enable_n = 1'b1;
      register_target_select = 1'b0;
   end
   // Waits a number of system clock edges.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Sends one frame; the data line is inverted once the frame closes.
   task automatic frame(input logic tgt, input int n,
      input logic [159:0] v);
      cyc(1);
      register_target_select <= tgt;
      cyc(4);
      chip_enable_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         cyc(4);
         serial_clk <= 1'b0;
         serial_data <= v[tgt ? n - 1 - i : i];
         cyc(4);
         serial_clk <= 1'b1;
      end
      cyc(4);
      chip_enable_n <= 1'b1;
      cyc(4);
      serial_clk <= 1'b0;
      serial_data <= ~serial_data;
      cyc(16);
   endtask
endmodule

// file: sim/tb_top.sv
// Self-checking testbench of the serial LED matrix loader.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t: got %0h expected %0h", $time, a, b); end end
module tb_top;
   import led_loader_pkg::*;
   localparam int TICK = 4;
   localparam int SPAN = REFRESH_CYCLES * TICK;
   localparam int TAB [16] = '{0, 1, 2, 3, 4, 5, 7, 9, 11, 14, 18, 22,
      28, 36, 48, 60};
   localparam logic [3:0] CODES [4] = '{4'h0, 4'h3, 4'h8, 4'hd};
   logic clk, reset_n, display_blank, osc_select, osc_in, oc;
   logic serial_clk, serial_data, chip_enable_n, register_target_select;
   logic serial_data_out, osc_out, osc_oe, load_ready;
   logic [19:0] column_drive;
   logic [6:0] row_drive;
   logic [1:0] peak_current;
   logic [159:0] pix, pat;
   logic [31:0] seed;
   int w0, failures, n_checks, cols, rows, t, tog;
   serial_host host (.clk(clk), .serial_clk(serial_clk),
      .serial_data(serial_data), .chip_enable_n(chip_enable_n),
      .register_target_select(register_target_select));
   led_matrix_serial_loader dut (.clk(clk),
      .reset_n(reset_n), .serial_clk(serial_clk),
      .serial_data(serial_data), .chip_enable_n(chip_enable_n),
      .register_target_select(register_target_select),
      .display_blank(display_blank), .osc_select(osc_select),
      .osc_in(osc_in), .serial_data_out(serial_data_out),
      .osc_out(osc_out), .osc_oe(osc_oe), .load_ready(load_ready),
      .column_drive(column_drive), .row_drive(row_drive),
      .peak_current(peak_current));
   // ==========================================================
   // Clocks
   // System clock of 20 ns.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // External display oscillator with one rising edge every TICK clocks.
   always @(posedge clk) begin
      oc <= ~oc;
      if (oc) osc_in <= ~osc_in;
   end
   // ==========================================================
   // Helpers
   // Draws 160 pseudo-random bits.
   function automatic logic [159:0] rnd160();
      logic [159:0] r;
      for (int k = 0; k < 5; k++) begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         r[k*32 +: 32] = seed;
      end
      return r;
   endfunction
   // Writes a control byte and updates the model of word 0.
   task automatic ctrl(input logic [7:0] b);
      host.frame(1'b1, CTRL_BITS, {152'h0, b});
      if (!b[SELECT_POS]) w0 = int'(b[6:0]);
   endtask
   // Compares the lit rows of every driven column with the model.
   task automatic scan(input int n);
      for (int k = 0; k < n; k++) begin
         @(negedge clk);
         for (int c = 0; c < COLUMNS; c++)
            if (column_drive[c] === 1'b1)
               `CHK(row_drive, pix[c*ROWS+1 +: 7])
      end
   endtask
   // Counts driven columns, driven rows and oscillator output changes.
   task automatic count(input int n);
      logic o;
      cols = 0;
      rows = 0;
      tog = 0;
      @(negedge clk);
      o = osc_out;
      for (int k = 0; k < n; k++) begin
         @(negedge clk);
         if (column_drive !== 20'h00000) cols++;
         if (row_drive !== 7'h00) rows++;
         if (osc_out !== o) tog++;
         o = osc_out;
      end
   endtask
   // Measures in t how many cycles one newly lit column stays driven.
   task automatic slot_len();
      logic [19:0] c;
      @(negedge clk);
      c = column_drive;
      do begin
         @(negedge clk);
      end while (column_drive === c || column_drive === 20'h00000);
      c = column_drive;
      t = 0;
      while (column_drive === c) begin
         @(negedge clk);
         t++;
      end
   endtask
   // Writes a pixel frame and waits for it to reach the scan.
   task automatic load(input logic [159:0] v);
      host.frame(1'b0, DOT_BITS, v);
      pix = v;
      host.cyc(120);
   endtask
   task automatic fin(input string s);
      $display("test %s done", s);
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("[ERR] %0t: watchdog expired", $time);
      test_done();
   end
   // ==========================================================
   // Tests
   initial begin
      {reset_n, display_blank, osc_in, oc} = 4'h0;
      osc_select = 1'b1;
      seed = 32'h000059eb;
      {failures, n_checks, w0} = '0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      host.cyc(6);
      `CHK(peak_current, 2'h0)
      osc_select <= 1'b0;
      fin("reset");
      load(rnd160());
      ctrl(8'h7f);
      `CHK(peak_current, 2'h3)
      `CHK(serial_data_out, 1'b0)
      scan(1000);
      ctrl(8'h80);
      `CHK(peak_current, 2'(w0 >> CURRENT_LSB))
      `CHK(serial_data_out, 1'b1)
      fin("control words");
      pat = rnd160();
      fork
         host.frame(1'b0, DOT_BITS, pat);
         scan(1000);
      join
      pix = pat;
      host.cyc(120);
      scan(1000);
      fin("pixel latch");
      for (int i = 0; i < 4; i++) begin
         ctrl({2'b01, i[1:0], CODES[i]});
         host.cyc(SPAN);
         `CHK(peak_current, i[1:0])
         count(SPAN);
         t = TAB[CODES[i]] > COLUMN_SLOT ? COLUMN_SLOT : TAB[CODES[i]];
         `CHK(cols, COLUMNS * t * TICK)
      end
      fin("brightness");
      ctrl(8'h3f);
      `CHK(peak_current, 2'h0)
      osc_select <= 1'b1;
      count(SPAN);
      `CHK(rows, 0)
      `CHK(tog, 0)
      `CHK(osc_oe, 1'b1)
      ctrl(8'h7f);
      count(8 * INT_OSC_DIV);
      `CHK(tog, 8)
      host.cyc(1);
      osc_select <= 1'b0;
      host.cyc(SPAN);
      `CHK(peak_current, 2'h3)
      `CHK(osc_oe, 1'b0)
      scan(SPAN);
      for (int p = 0; p < 2; p++) begin
         ctrl({1'b1, 5'h00, p[0], p[0]});
         slot_len();
         `CHK(t, COLUMN_SLOT * TICK * (p ? PRESCALE_DIV : 1))
      end
      fork
         ctrl(8'h80);
         repeat (90) begin
            @(negedge clk);
            if (serial_clk === 1'b1 && chip_enable_n === 1'b0)
               `CHK(serial_data_out, serial_data)
         end
      join
      fin("sleep and oscillator");
      host.cyc(1);
      display_blank <= 1'b1;
      host.cyc(4);
      count(SPAN);
      `CHK(rows, 0)
      pat = rnd160();
      for (int k = 0; k < 64; k++) begin
         host.cyc(1);
         display_blank <= pat[k];
         host.cyc(4);
         @(negedge clk);
         if (pat[k]) `CHK(row_drive, 7'h00)
         else scan(1);
      end
      host.cyc(1);
      display_blank <= 1'b0;
      fin("blank");
      reset_n <= 1'b0;
      host.cyc(5);
      reset_n <= 1'b1;
      w0 = 0;
      host.cyc(6);
      `CHK(peak_current, 2'h0)
      ctrl(8'h7f);
      host.cyc(200);
      scan(1000);
      fin("second reset");
      test_done();
   end
endmodule
